/* pkg/daabs_pkg.sv */
package daabs_pkg;

    ////////////////////////////////////////////////////////////////
    // Address widths
    localparam int ADDR_W = 23;
    localparam int HIGH_W = 7;
    localparam int LOW_W = 16;
    localparam int OFS_W = 7;
    localparam int EXT_W = 24;

    ////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DPAGE_PTR = 8'h04;
    localparam logic [7:0] OFF_DPAGE_HIGH = 8'h08;
    localparam logic [7:0] OFF_STACK_LOW = 8'h0C;
    localparam logic [7:0] OFF_STACK_HIGH = 8'h10;
    localparam logic [7:0] OFF_EXT_BYTE = 8'h14;
    localparam logic [7:0] OFF_COMMAND = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_FIRST = 8'h20;
    localparam logic [7:0] OFF_SECOND = 8'h24;

    ////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CMD_MODE_LSB = 0;
    localparam int CMD_LONG_BIT = 2;
    localparam int CMD_WRITE_BIT = 3;
    localparam int CMD_PAR_BIT = 4;
    localparam int CMD_OFS_LSB = 8;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_PAR_BIT = 1;
    localparam int ST_EXT_BIT = 2;
    localparam int ST_MODE_BIT = 3;
    localparam int ST_BUSY_BIT = 4;
    localparam int EXT_CNT_LSB = 24;
    localparam int OFS_MASK_LSB = 0;

    ////////////////////////////////////////////////////////////////
    // Reset values and counts
    localparam logic [LOW_W-1:0] RST_LOW = 16'h0000;
    localparam logic [HIGH_W-1:0] RST_HIGH = 7'h00;
    localparam logic [EXT_W-1:0] RST_EXT = 24'h000000;
    localparam logic [1:0] EXT_CNT_SHORT = 2'h2;
    localparam logic [1:0] EXT_CNT_LONG = 2'h3;
    localparam logic [OFS_W-1:0] OFS_MASK = 7'h7F;

    ////////////////////////////////////////////////////////////////
    // Operand modes
    typedef enum logic [1:0] {
        DAABS_ABS_SHORT = 2'h0,
        DAABS_ABS_LONG = 2'h1,
        DAABS_DIRECT = 2'h2,
        DAABS_RESERVED = 2'h3
    } daabs_mode_t;

    typedef struct packed {
        logic valid;
        logic is_long;
        logic write;
        logic [ADDR_W-1:0] first;
        logic [ADDR_W-1:0] second;
    } daabs_dmem_t;

    // Byte-enable merge of a bus write
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] be
    );
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

endpackage

/* logic/daabs_addr_gen.sv */
`timescale 1ns/1ps
`default_nettype none

module daabs_addr_gen (
    input wire daabs_pkg::daabs_mode_t mode_in, // Operand mode
    input wire logic cpl_in, // Compiler layout bit
    input wire logic [6:0] dph_in, // Data page high
    input wire logic [15:0] dpp_in, // Data page pointer
    input wire logic [15:0] spl_in, // Stack pointer low
    input wire logic [6:0] sph_in, // Stack pointer high
    input wire logic [6:0] ofs_in, // Direct offset
    input wire logic [23:0] ext_in, // Extension bytes
    output logic [22:0] first_out, // First word address
    output logic [22:0] second_out // Second word address
);
    import daabs_pkg::*;

    function automatic logic [ADDR_W-1:0] pair_addr(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] one;
        one = 23'h000001;
        return a[0] ? a - one : a + one;
    endfunction

    wire [OFS_W-1:0] ofs_m = ofs_in & OFS_MASK;
    wire [LOW_W-1:0] ofs_x = {9'h000, ofs_m};
    wire [LOW_W-1:0] page_sum = dpp_in + ofs_x;
    wire [LOW_W-1:0] stack_sum = spl_in + ofs_x;
    wire [ADDR_W-1:0] a_short = {dph_in, ext_in[15:0]};
    wire [ADDR_W-1:0] a_long = ext_in[22:0];
    wire [ADDR_W-1:0] a_page = {dph_in, page_sum};
    wire [ADDR_W-1:0] a_stack = {sph_in, stack_sum};
    wire [ADDR_W-1:0] a_direct = cpl_in ? a_stack : a_page;

    assign first_out = (mode_in == DAABS_ABS_SHORT) ? a_short :
                       (mode_in == DAABS_ABS_LONG) ? a_long : a_direct;
    assign second_out = pair_addr(first_out);

endmodule

`default_nettype wire

/* logic/daabs_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Accept short and long absolute constants
// - Single moves 16 bits, long 32
// - Absolute operand never issued in parallel
// - Short constant from two extension bytes
// - Long constant from three extension bytes
// - Short absolute: page high with constant
// - Long absolute: constant is full address
// - Layout bit selects page or stack
// - Direct offset is seven bits, masked
// - Page direct: high with pointer plus offset
// - Odd first address pairs with preceding word
// - Stack direct: high with pointer plus offset
// - Second address plus one even, minus odd
module daabs_top (
    input wire logic clock_in, // System clock
    input wire logic rstn_in, // Async reset, low
    input wire logic [7:0] avs_address_in, // Byte address
    input wire logic avs_read_in, // Read strobe
    input wire logic avs_write_in, // Write strobe
    input wire logic [31:0] avs_writedata_in, // Write data
    input wire logic [3:0] avs_byteenable_in, // Byte lanes
    output logic [31:0] avs_readdata_out, // Read data
    output logic avs_waitrequest_out, // Stall
    output daabs_pkg::daabs_dmem_t dmem_req_out // Address request
);
    import daabs_pkg::*;

    ////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [1:0] {
        DAABS_IDLE = 2'b01,
        DAABS_CALC = 2'b10
    } daabs_state_t;

    daabs_state_t state_q;
    daabs_state_t state_d;
    logic ack_q;
    logic [31:0] rdata_q;
    logic cpl_q;
    logic [LOW_W-1:0] dpp_q;
    logic [HIGH_W-1:0] dph_q;
    logic [LOW_W-1:0] spl_q;
    logic [HIGH_W-1:0] sph_q;
    logic [EXT_W-1:0] ext_q;
    logic [1:0] ext_cnt_q;
    logic [31:0] cmd_q;
    logic [EXT_W-1:0] cmd_ext_q;
    logic [1:0] cmd_cnt_q;
    logic done_q;
    logic par_err_q;
    logic ext_err_q;
    logic mode_err_q;
    logic [ADDR_W-1:0] first_q;
    logic [ADDR_W-1:0] second_q;
    daabs_dmem_t dmem_q;

    ////////////////////////////////////////////////////////////////
    // Bus handshake: one wait state per access
    wire bus_req = avs_read_in | avs_write_in;
    wire rd_take = avs_read_in & ~ack_q;
    wire wr_commit = avs_write_in & ack_q;

    assign avs_waitrequest_out = bus_req & ~ack_q;
    assign avs_readdata_out = rdata_q;

    wire [7:0] wa = {avs_address_in[7:2], 2'b00};
    wire hit_ctrl = (wa == OFF_CTRL);
    wire hit_dpp = (wa == OFF_DPAGE_PTR);
    wire hit_dph = (wa == OFF_DPAGE_HIGH);
    wire hit_spl = (wa == OFF_STACK_LOW);
    wire hit_sph = (wa == OFF_STACK_HIGH);
    wire hit_ext = (wa == OFF_EXT_BYTE);
    wire hit_cmd = (wa == OFF_COMMAND);
    wire hit_st = (wa == OFF_STATUS);
    wire hit_first = (wa == OFF_FIRST);
    wire hit_second = (wa == OFF_SECOND);

    ////////////////////////////////////////////////////////////////
    // Write data after byte enables
    wire [31:0] w_ctrl = be_merge({31'h00000000, cpl_q},
                                  avs_writedata_in, avs_byteenable_in);
    wire [31:0] w_dpp = be_merge({16'h0000, dpp_q},
                                 avs_writedata_in, avs_byteenable_in);
    wire [31:0] w_dph = be_merge({25'h0000000, dph_q},
                                 avs_writedata_in, avs_byteenable_in);
    wire [31:0] w_spl = be_merge({16'h0000, spl_q},
                                 avs_writedata_in, avs_byteenable_in);
    wire [31:0] w_sph = be_merge({25'h0000000, sph_q},
                                 avs_writedata_in, avs_byteenable_in);
    wire [31:0] w_cmd = be_merge(cmd_q, avs_writedata_in, avs_byteenable_in);
    wire [31:0] w_st = avs_writedata_in & {{8{avs_byteenable_in[3]}},
                       {8{avs_byteenable_in[2]}}, {8{avs_byteenable_in[1]}},
                       {8{avs_byteenable_in[0]}}};

    wire ext_push = wr_commit & hit_ext & avs_byteenable_in[0];
    wire cmd_launch = wr_commit & hit_cmd & (state_q == DAABS_IDLE);
    wire st_write = wr_commit & hit_st;

    ////////////////////////////////////////////////////////////////
    // Command fields
    wire daabs_mode_t cmd_mode = daabs_mode_t'(cmd_q[CMD_MODE_LSB +: 2]);
    wire cmd_long = cmd_q[CMD_LONG_BIT];
    wire cmd_write = cmd_q[CMD_WRITE_BIT];
    wire cmd_par = cmd_q[CMD_PAR_BIT];
    wire [OFS_W-1:0] cmd_ofs = cmd_q[CMD_OFS_LSB +: OFS_W];

    wire is_abs = (cmd_mode == DAABS_ABS_SHORT) | (cmd_mode == DAABS_ABS_LONG);
    wire bad_par = is_abs & cmd_par;
    wire bad_ext = ((cmd_mode == DAABS_ABS_SHORT) & (cmd_cnt_q < EXT_CNT_SHORT))
                 | ((cmd_mode == DAABS_ABS_LONG) & (cmd_cnt_q != EXT_CNT_LONG));
    wire bad_mode = (cmd_mode == DAABS_RESERVED);
    wire calc = (state_q == DAABS_CALC);
    wire calc_ok = calc & ~bad_par & ~bad_ext & ~bad_mode;

    ////////////////////////////////////////////////////////////////
    // Address arithmetic
    logic [ADDR_W-1:0] gen_first;
    logic [ADDR_W-1:0] gen_second;

    daabs_addr_gen u_gen (
        .mode_in(cmd_mode),
        .cpl_in(cpl_q),
        .dph_in(dph_q),
        .dpp_in(dpp_q),
        .spl_in(spl_q),
        .sph_in(sph_q),
        .ofs_in(cmd_ofs),
        .ext_in(cmd_ext_q),
        .first_out(gen_first),
        .second_out(gen_second)
    );

    ////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            DAABS_IDLE: begin
                if (cmd_launch) begin
                    state_d = DAABS_CALC;
                end
            end
            DAABS_CALC: begin
                state_d = DAABS_IDLE;
            end
            default: begin
                state_d = DAABS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= DAABS_IDLE;
            ack_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ack_q <= bus_req & ~ack_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read mux
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_ctrl) begin
            rd_mux = {31'h00000000, cpl_q};
        end else if (hit_dpp) begin
            rd_mux = {16'h0000, dpp_q};
        end else if (hit_dph) begin
            rd_mux = {25'h0000000, dph_q};
        end else if (hit_spl) begin
            rd_mux = {16'h0000, spl_q};
        end else if (hit_sph) begin
            rd_mux = {25'h0000000, sph_q};
        end else if (hit_ext) begin
            rd_mux = {6'h00, ext_cnt_q, ext_q};
        end else if (hit_cmd) begin
            rd_mux = cmd_q;
        end else if (hit_st) begin
            rd_mux = {27'h0000000, calc, mode_err_q, ext_err_q,
                      par_err_q, done_q};
        end else if (hit_first) begin
            rd_mux = {9'h000, first_q};
        end else if (hit_second) begin
            rd_mux = {9'h000, second_q};
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= 32'h00000000;
        end else if (rd_take) begin
            rdata_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pointer registers
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cpl_q <= 1'b0;
            dpp_q <= RST_LOW;
            dph_q <= RST_HIGH;
            spl_q <= RST_LOW;
            sph_q <= RST_HIGH;
        end else if (wr_commit) begin
            if (hit_ctrl) cpl_q <= w_ctrl[0];
            if (hit_dpp) dpp_q <= w_dpp[LOW_W-1:0];
            if (hit_dph) dph_q <= w_dph[HIGH_W-1:0];
            if (hit_spl) spl_q <= w_spl[LOW_W-1:0];
            if (hit_sph) sph_q <= w_sph[HIGH_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Extension bytes, first byte most significant
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_q <= RST_EXT;
            ext_cnt_q <= 2'h0;
        end else if (cmd_launch) begin
            ext_cnt_q <= 2'h0;
        end else if (ext_push) begin
            ext_q <= {ext_q[15:0], avs_writedata_in[7:0]};
            if (ext_cnt_q != EXT_CNT_LONG) ext_cnt_q <= ext_cnt_q + 2'h1;
        end
    end

    // Command snapshot with the extension it consumes
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_q <= 32'h00000000;
            cmd_ext_q <= RST_EXT;
            cmd_cnt_q <= 2'h0;
        end else if (cmd_launch) begin
            cmd_q <= w_cmd;
            cmd_ext_q <= ext_q;
            cmd_cnt_q <= ext_cnt_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status flags: set beats clear
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            done_q <= 1'b0;
            par_err_q <= 1'b0;
            ext_err_q <= 1'b0;
            mode_err_q <= 1'b0;
        end else begin
            done_q <= calc_ok | (done_q & ~(st_write & w_st[ST_DONE_BIT]));
            par_err_q <= (calc & bad_par)
                       | (par_err_q & ~(st_write & w_st[ST_PAR_BIT]));
            ext_err_q <= (calc & bad_ext)
                       | (ext_err_q & ~(st_write & w_st[ST_EXT_BIT]));
            mode_err_q <= (calc & bad_mode)
                        | (mode_err_q & ~(st_write & w_st[ST_MODE_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////
    // Results and data-memory request
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            first_q <= 23'h000000;
            second_q <= 23'h000000;
            dmem_q <= '0;
        end else begin
            dmem_q.valid <= calc_ok;
            if (calc_ok) begin
                first_q <= gen_first;
                second_q <= cmd_long ? gen_second : gen_first;
                dmem_q.is_long <= cmd_long;
                dmem_q.write <= cmd_write;
                dmem_q.first <= gen_first;
                dmem_q.second <= cmd_long ? gen_second : gen_first;
            end
        end
    end

    assign dmem_req_out = dmem_q;

endmodule

`default_nettype wire

/* logic/daabs_unused_placeholder_never.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* testbench/daabs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module daabs_props (
    input wire logic clock_in, // Clock
    input wire logic rstn_in, // Reset
    input wire logic [7:0] avs_address_in, // Address
    input wire logic avs_read_in, // Read
    input wire logic avs_write_in, // Write
    input wire logic [31:0] avs_writedata_in, // Write data
    input wire logic avs_waitrequest_out, // Stall
    input wire daabs_pkg::daabs_dmem_t dmem_req_out // Request
);
    import daabs_pkg::*;
    wire logic cmd_commit = avs_write_in && !avs_waitrequest_out
        && (avs_address_in[7:2] == OFF_COMMAND[7:2]);
    wire logic vld = dmem_req_out.valid;
    logic [1:0] since_q;
    logic [31:0] cmd_q;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            since_q <= 2'h3;
            cmd_q <= 32'h0;
        end else if (cmd_commit) begin
            since_q <= 2'h0;
            cmd_q <= avs_writedata_in;
        end else if (since_q != 2'h3) begin
            since_q <= since_q + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    sequence bus_ack_s;
        avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence
    stall_first_a: assert property ($rose(avs_read_in || avs_write_in) |-> bus_ack_s)
        else $error("first bus cycle not stalled");
    idle_free_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("stall while idle");
    valid_pulse_a: assert property (vld |=> !vld)
        else $error("request valid longer than one cycle");
    valid_cause_a: assert property (vld |-> since_q < 2'h2)
        else $error("request without recent command");
    single_same_a: assert property (vld && !dmem_req_out.is_long |->
        dmem_req_out.second == dmem_req_out.first) else $error("single second differs");
    long_even_a: assert property (vld && dmem_req_out.is_long && !dmem_req_out.first[0] |->
        dmem_req_out.second == dmem_req_out.first + 23'h1) else $error("even pair wrong");
    long_odd_a: assert property (vld && dmem_req_out.is_long && dmem_req_out.first[0] |->
        dmem_req_out.second == dmem_req_out.first - 23'h1) else $error("odd pair wrong");
    shape_match_a: assert property (vld |-> dmem_req_out.is_long == cmd_q[2]
        && dmem_req_out.write == cmd_q[3]) else $error("request shape differs");
    no_parallel_a: assert property (vld |-> !(cmd_q[4] && !cmd_q[1]))
        else $error("absolute operand issued in parallel");
    mode_known_a: assert property (vld |-> cmd_q[1:0] != 2'h3)
        else $error("reserved mode produced request");
endmodule
bind daabs_top daabs_props chk_u (.clock_in(clock_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_waitrequest_out(avs_waitrequest_out), .dmem_req_out(dmem_req_out));
`default_nettype wire

/* testbench/daabs_dmem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module daabs_dmem_model (
    input wire logic clock_in, // Clock
    input wire logic rstn_in, // Reset
    input wire daabs_pkg::daabs_dmem_t req_in, // Address request
    output var daabs_pkg::daabs_dmem_t last_out, // Last request taken
    output var logic [7:0] count_out // Requests taken
);
    import daabs_pkg::*;
    // Memory side takes each one-cycle request
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last_out <= '0;
            count_out <= 8'h00;
        end else if (req_in.valid) begin
            last_out <= req_in;
            count_out <= count_out + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* testbench/daabs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module daabs_bench;
    import daabs_pkg::*;
    logic clock_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [7:0] avs_address_in, seen;
    logic [31:0] avs_writedata_in, avs_readdata_out, rd;
    daabs_dmem_t dmem_req_out, last;
    int failures = 0;
    int checked = 0;
    daabs_top dut_u (.clock_in(clock_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .dmem_req_out(dmem_req_out));
    daabs_dmem_model mem_u (.clock_in(clock_in), .rstn_in(rstn_in), .req_in(dmem_req_out),
        .last_out(last), .count_out(seen));
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task automatic push(input logic [7:0] b);
        bus(1'b1, OFF_EXT_BYTE, {24'h0, b});
    endtask
    task automatic cmd(input logic [31:0] c, input logic [22:0] f, input logic [22:0] s,
        input logic ok);
        logic [7:0] n;
        n = seen;
        bus(1'b1, OFF_COMMAND, c);
        repeat (4) @(posedge clock_in);
        chk(32'(seen), 32'(ok ? n + 8'h01 : n));
        if (ok) begin
            chk(32'(last.first), 32'(f));
            chk(32'(last.second), 32'(s));
            chk(32'(last.is_long), 32'(c[CMD_LONG_BIT]));
            chk(32'(last.write), 32'(c[CMD_WRITE_BIT]));
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] regs [5] = '{OFF_CTRL, OFF_DPAGE_HIGH, OFF_STATUS, OFF_FIRST, 8'h30};
        bus(1'b1, 8'h30, 32'hFFFFFFFF);
        foreach (regs[i]) begin
            bus(1'b0, regs[i], 32'h0);
            chk(rd, 32'h0);
        end
    endtask
    task automatic t_abs();
        bus(1'b1, OFF_DPAGE_HIGH, 32'h3);
        push(8'h20);
        push(8'h02);
        cmd(32'h4, 23'h032002, 23'h032003, 1'b1);
        bus(1'b0, OFF_FIRST, 32'h0);
        chk(rd, 32'h032002);
        bus(1'b0, OFF_SECOND, 32'h0);
        chk(rd, 32'h032003);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        bus(1'b1, OFF_STATUS, 32'h1);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0);
        push(8'h03);
        push(8'h20);
        push(8'h02);
        cmd(32'h1, 23'h032002, 23'h032002, 1'b1);
        push(8'h83);
        push(8'h20);
        push(8'h01);
        cmd(32'hD, 23'h032001, 23'h032000, 1'b1);
    endtask
    task automatic t_direct();
        bus(1'b1, OFF_CTRL, 32'h0);
        bus(1'b1, OFF_DPAGE_PTR, 32'h0);
        cmd(32'h0506, 23'h030005, 23'h030004, 1'b1);
        bus(1'b1, OFF_DPAGE_PTR, 32'hFFFE);
        cmd(32'h7F06, 23'h03007D, 23'h03007C, 1'b1);
        bus(1'b1, OFF_CTRL, 32'h1);
        bus(1'b1, OFF_STACK_LOW, 32'hFF00);
        cmd(32'h0506, 23'h00FF05, 23'h00FF04, 1'b1);
        cmd(32'h050A, 23'h00FF05, 23'h00FF05, 1'b1);
    endtask
    task automatic t_refuse();
        push(8'h20);
        cmd(32'h0, 23'h0, 23'h0, 1'b0);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h4);
        push(8'h20);
        push(8'h02);
        cmd(32'h10, 23'h0, 23'h0, 1'b0);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(rd & 32'h2, 32'h2);
        cmd(32'h3, 23'h0, 23'h0, 1'b0);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(rd & 32'h8, 32'h8);
        bus(1'b0, OFF_FIRST, 32'h0);
        chk(rd, 32'h00FF05);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rstn_in = 1'b0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_address_in = 8'h00;
        avs_writedata_in = 32'h0;
        repeat (20) @(posedge clock_in);
        rstn_in <= 1'b1;
        t_reset();
        t_abs();
        t_direct();
        t_refuse();
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clock_in);
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
